// *** rtl/link_bit_capture.sv ***
// Link clock domain: captures the data pin on each falling programmer clock edge.
`default_nettype none

module link_bit_capture (
    input  wire logic i_link_clk,
    input  wire logic i_rst,
    input  wire logic i_data_in,
    output var  logic o_bit,
    output var  logic o_toggle
);

    logic next_bit;
    logic next_toggle;

    ////////////////////////////////////////////////////////////////////////////////
    // Each falling edge holds the sampled bit and flips the event toggle.

    always_comb begin
        next_bit    = i_data_in;
        next_toggle = ~o_toggle;
    end

    // The link clock stands still outside frames, so reset acts without it.
    always_ff @(negedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bit    <= 1'b0;
            o_toggle <= 1'b0;
        end else begin
            o_bit    <= next_bit;
            o_toggle <= next_toggle;
        end
    end

endmodule

`default_nettype wire

// *** rtl/serial_program_verify_port.sv ***
// Device side of the serial program/verify port with word memory and write timing.
//
// Operation
// - Exactly one verify read-out is given, only after the final word is written.
// - Verify words follow one another with no acknowledge bit between them.
// - Variants without verify never drive read-out data.
// - Only pulse-emitting variants toggle the data pin while a write completion is polled.
// - Words are 16 clocks long, captured on falling edges and sampled on rising edges.
// - While polled the data pin is low until the write ends, then high, or pulsing in pulse-emitting variants, until clock falls.
// - After entry the memory is erased to zeros for at least 4.0 ms before data is taken.
`default_nettype none

module serial_program_verify_port #(
    parameter int unsigned ERASE_CYCLES    = spv_pkg::ERASE_CYCLES_DEF,
    parameter int unsigned WRITE_CYCLES    = spv_pkg::WRITE_CYCLES_DEF,
    parameter int unsigned CAL_HALF_CYCLES = spv_pkg::CAL_HALF_CYCLES_DEF,
    parameter bit          HAS_VERIFY      = 1'b1,
    parameter bit          PULSE_ON_POLL   = 1'b0
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_link_clk,
    input  wire logic i_data_in,
    output var  logic o_data_out,
    output var  logic o_data_oe,
    output var  logic o_prog_mode,
    output var  logic o_write_busy,
    output var  logic o_verify_spent
);

    import spv_pkg::*;

    localparam logic [TIMER_W-1:0] ERASE_LAST = TIMER_W'(ERASE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] WRITE_LAST = TIMER_W'(WRITE_CYCLES - 1);
    localparam logic [TIMER_W-1:0] CAL_LAST   = TIMER_W'(CAL_HALF_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Link capture and crossings.

    logic link_bit;
    logic link_toggle;

    link_bit_capture u_capture (
        .i_link_clk (i_link_clk),
        .i_rst      (i_rst),
        .i_data_in  (i_data_in),
        .o_bit      (link_bit),
        .o_toggle   (link_toggle)
    );

    logic clk_meta;
    logic clk_sync;
    logic data_meta;
    logic data_sync;
    logic tog_meta;
    logic tog_sync;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            clk_meta  <= 1'b0;
            clk_sync  <= 1'b0;
            data_meta <= 1'b0;
            data_sync <= 1'b0;
            tog_meta  <= 1'b0;
            tog_sync  <= 1'b0;
        end else begin
            clk_meta  <= i_link_clk;
            clk_sync  <= clk_meta;
            data_meta <= i_data_in;
            data_sync <= data_meta;
            tog_meta  <= link_toggle;
            tog_sync  <= tog_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer state.

    state_t                 state;
    logic [TIMER_W-1:0]     timer;
    logic [ADDR_W-1:0]      addr;
    logic [BIT_CNT_W-1:0]   bit_cnt;
    logic [WORD_W-1:0]      shift;
    logic                   tog_seen;
    logic                   cal_level;
    logic [WORD_W-1:0]      mem [WORD_COUNT];

    state_t                 next_state;
    logic [TIMER_W-1:0]     next_timer;
    logic [ADDR_W-1:0]      next_addr;
    logic [BIT_CNT_W-1:0]   next_bit_cnt;
    logic [WORD_W-1:0]      next_shift;
    logic                   next_tog_seen;
    logic                   next_cal_level;
    logic [WORD_W-1:0]      next_mem [WORD_COUNT];
    logic                   next_data_out;
    logic                   next_data_oe;
    logic                   next_prog_mode;
    logic                   next_write_busy;
    logic                   next_verify_spent;
    logic                   bit_evt;

    always_comb begin
        next_state        = state;
        next_timer        = timer;
        next_addr         = addr;
        next_bit_cnt      = bit_cnt;
        next_shift        = shift;
        next_cal_level    = cal_level;
        next_mem          = mem;
        next_verify_spent = o_verify_spent;
        // The held link bit is stable for a whole clock phase once its toggle is seen.
        bit_evt           = tog_sync != tog_seen;
        next_tog_seen     = tog_sync;

        case (state)
            ST_IDLE: begin
                if (clk_sync && !data_sync) begin
                    next_state = ST_ENTRY_CLK;
                end
            end
            ST_ENTRY_CLK: begin
                if (!clk_sync) begin
                    next_state = ST_IDLE;
                end else if (data_sync) begin
                    next_state = ST_ENTRY_BOTH;
                end
            end
            ST_ENTRY_BOTH: begin
                if (!clk_sync && !data_sync) begin
                    next_state = ST_ERASE;
                    next_timer = '0;
                    for (int i = 0; i < WORD_COUNT; i++) begin
                        next_mem[i] = ERASED_WORD;
                    end
                end else if (!clk_sync || !data_sync) begin
                    next_state = ST_IDLE;
                end
            end
            ST_ERASE: begin
                // Edges seen during erase, such as the entry fall, are dropped.
                next_timer = timer + 1'b1;
                if (timer == ERASE_LAST) begin
                    next_state   = ST_RECV;
                    next_addr    = '0;
                    next_bit_cnt = '0;
                end
            end
            ST_RECV: begin
                if (bit_evt) begin
                    // First bit in lands in bit 0.
                    next_shift   = {link_bit, shift[WORD_W-1:1]};
                    next_bit_cnt = bit_cnt + 1'b1;
                    if (bit_cnt == LAST_BIT) begin
                        next_state = ST_WRITE;
                        next_timer = '0;
                    end
                end
            end
            ST_WRITE: begin
                next_timer = timer + 1'b1;
                if (timer == WRITE_LAST) begin
                    next_mem[addr] = shift;
                    next_timer     = '0;
                    next_cal_level = 1'b1;
                    if (clk_sync) begin
                        next_state = ST_POLL;
                    end else if (addr != LAST_ADDR) begin
                        next_state = ST_RECV;
                        next_addr  = addr + 1'b1;
                    end else begin
                        next_state = HAS_VERIFY ? ST_VERIFY : ST_DONE;
                        next_addr  = '0;
                    end
                end
            end
            ST_POLL: begin
                next_timer = timer + 1'b1;
                if (timer == CAL_LAST) begin
                    next_timer     = '0;
                    next_cal_level = ~cal_level;
                end
                // The fall that ends polling arrives as a link event and is consumed here.
                if (bit_evt) begin
                    next_bit_cnt = '0;
                    if (addr != LAST_ADDR) begin
                        next_state = ST_RECV;
                        next_addr  = addr + 1'b1;
                    end else begin
                        next_state = HAS_VERIFY ? ST_VERIFY : ST_DONE;
                        next_addr  = '0;
                    end
                end
            end
            ST_VERIFY: begin
                if (bit_evt) begin
                    // Words run back to back with no acknowledge slot.
                    next_bit_cnt = bit_cnt + 1'b1;
                    if (bit_cnt == LAST_BIT) begin
                        next_addr = addr + 1'b1;
                        if (addr == LAST_ADDR) begin
                            next_state        = ST_DONE;
                            next_verify_spent = 1'b1;
                        end
                    end
                end
            end
            ST_DONE: begin
                next_state = ST_DONE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        next_data_out = 1'b0;
        next_data_oe  = 1'b0;
        case (next_state)
            ST_WRITE: begin
                // Low only while the programmer holds the clock high to poll.
                next_data_oe = clk_sync;
            end
            ST_POLL: begin
                next_data_oe  = 1'b1;
                next_data_out = PULSE_ON_POLL ? next_cal_level : 1'b1;
            end
            ST_VERIFY: begin
                next_data_oe  = 1'b1;
                next_data_out = next_mem[next_addr][next_bit_cnt];
            end
            default: begin
                next_data_oe  = 1'b0;
            end
        endcase

        next_prog_mode  = (next_state != ST_IDLE) && (next_state != ST_ENTRY_CLK)
                          && (next_state != ST_ENTRY_BOTH);
        next_write_busy = (next_state == ST_WRITE) || (next_state == ST_ERASE);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state          <= ST_IDLE;
            timer          <= '0;
            addr           <= '0;
            bit_cnt        <= '0;
            shift          <= '0;
            tog_seen       <= 1'b0;
            cal_level      <= 1'b0;
            o_data_out     <= 1'b0;
            o_data_oe      <= 1'b0;
            o_prog_mode    <= 1'b0;
            o_write_busy   <= 1'b0;
            o_verify_spent <= 1'b0;
        end else begin
            state          <= next_state;
            timer          <= next_timer;
            addr           <= next_addr;
            bit_cnt        <= next_bit_cnt;
            shift          <= next_shift;
            tog_seen       <= next_tog_seen;
            cal_level      <= next_cal_level;
            o_data_out     <= next_data_out;
            o_data_oe      <= next_data_oe;
            o_prog_mode    <= next_prog_mode;
            o_write_busy   <= next_write_busy;
            o_verify_spent <= next_verify_spent;
        end
    end

    // Memory has no reset; it is cleared by the bulk erase after entry.
    always_ff @(posedge i_clk_sys) begin
        mem <= next_mem;
    end

endmodule

`default_nettype wire

// *** rtl/spv_pkg.sv ***
// Constants, timing and state encoding shared by the serial program/verify port.
`default_nettype none

package spv_pkg;

    localparam int unsigned SYS_CLK_HZ    = 125_000_000;
    localparam int unsigned WORD_W        = 16;
    localparam int unsigned WORD_COUNT    = 16;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned BIT_CNT_W     = 4;
    localparam int unsigned TIMER_W       = 23;

    localparam logic [ADDR_W-1:0]    LAST_ADDR  = 4'hF;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT   = 4'hF;
    localparam logic [WORD_W-1:0]    ERASED_WORD = 16'h0000;

    // Bulk erase least time, write cycle least time, calibration pulse half period.
    localparam real ERASE_TIME_MS     = 4.0;
    localparam real WRITE_TIME_MS     = 50.0;
    localparam real CAL_HALF_TIME_US  = 800.0;

    localparam int unsigned ERASE_CYCLES_DEF =
        int'($ceil(ERASE_TIME_MS * SYS_CLK_HZ / 1000.0));
    localparam int unsigned WRITE_CYCLES_DEF =
        int'($ceil(WRITE_TIME_MS * SYS_CLK_HZ / 1000.0));
    localparam int unsigned CAL_HALF_CYCLES_DEF =
        int'($ceil(CAL_HALF_TIME_US * SYS_CLK_HZ / 1000000.0));

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ENTRY_CLK,
        ST_ENTRY_BOTH,
        ST_ERASE,
        ST_RECV,
        ST_WRITE,
        ST_POLL,
        ST_VERIFY,
        ST_DONE
    } state_t;

endpackage

`default_nettype wire

// *** verif/serial_program_verify_port_tb.sv ***
// Self-checking bench for the serial program/verify port.
`default_nettype none

module serial_program_verify_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spv_pkg::*;
    localparam int unsigned ERASE = 40;
    localparam int unsigned CAL   = 10;
    // Pulse period in ns: two calibration half periods of the 8 ns system clock.
    localparam logic [15:0] PERIOD_NS = 16'(2 * CAL * 8);
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    wire  link_clk;
    wire  data_in;
    logic data_out;
    logic data_oe;
    logic prog_mode;
    logic write_busy;
    logic verify_spent;
    wire  link_clk_b;
    wire  data_in_b;
    logic data_out_b;
    logic data_oe_b;
    logic prog_mode_b;
    logic write_busy_b;
    logic verify_spent_b;
    int   miscompares = 0;
    int   check_count = 0;
    int   cycles = 0;

    always #4 clk = ~clk;
    always #6 tick = ~tick;

    serial_program_verify_port #(.ERASE_CYCLES(ERASE), .WRITE_CYCLES(200),
        .CAL_HALF_CYCLES(10)) u_dut (
        .i_clk_sys(clk), .i_rst(rst), .i_link_clk(link_clk), .i_data_in(data_in),
        .o_data_out(data_out), .o_data_oe(data_oe), .o_prog_mode(prog_mode),
        .o_write_busy(write_busy), .o_verify_spent(verify_spent));

    spv_programmer u_prog (.i_tick(tick), .i_data_oe(data_oe), .i_data_out(data_out),
        .o_link_clk(link_clk), .o_data_in(data_in));

    // Second variant: no read-out, calibration pulses while polled.
    serial_program_verify_port #(.ERASE_CYCLES(ERASE), .WRITE_CYCLES(200),
        .CAL_HALF_CYCLES(CAL), .HAS_VERIFY(1'b0), .PULSE_ON_POLL(1'b1)) u_dut_b (
        .i_clk_sys(clk), .i_rst(rst), .i_link_clk(link_clk_b), .i_data_in(data_in_b),
        .o_data_out(data_out_b), .o_data_oe(data_oe_b), .o_prog_mode(prog_mode_b),
        .o_write_busy(write_busy_b), .o_verify_spent(verify_spent_b));

    spv_programmer u_prog_b (.i_tick(tick), .i_data_oe(data_oe_b), .i_data_out(data_out_b),
        .o_link_clk(link_clk_b), .o_data_in(data_in_b));

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] pat(input logic [3:0] a);
        return {4{a}} ^ 16'h5A3C;
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic t_entry();
        check(prog_mode, 1'b0);
        u_prog.entry();
        check({prog_mode, write_busy}, 2'h3);
        repeat (ERASE) @(negedge clk);
        check(write_busy, 1'b0);
        $display("entry and erase done");
    endtask

    task automatic t_program();
        for (int a = 0; a < 16; a++) begin
            u_prog.send_word(pat(a[3:0]));
            if (a[0]) begin
                u_prog.ph(1'b1, 1'b0, 1'b0);
                check({write_busy, data_in}, 2'h2);
                u_prog.poll();
                check(data_in, 1'b1);
                u_prog.ph(1'b0, 1'b0, 1'b0);
            end else begin
                u_prog.wait_write();
            end
        end
        $display("sixteen words written");
    endtask

    task automatic t_verify();
        logic [15:0] w;
        for (int a = 0; a < 17; a++) begin
            for (int i = 0; i < 16; i++) begin
                u_prog.read_bit(w[i]);
            end
            check(w, a < 16 ? pat(a[3:0]) : 16'h0000);
        end
        check({verify_spent, data_oe}, 2'h2);
        $display("verify read-out done");
    endtask

    task automatic t_variant();
        logic [15:0] w;
        int unsigned per;
        check({prog_mode_b, data_oe_b}, 2'h0);
        u_prog_b.entry();
        u_prog_b.setup();
        check({prog_mode_b, write_busy_b}, 2'h2);
        for (int a = 0; a < 16; a++) begin
            // Tuning value -8, then +7, then the interpolated value in the low nibble.
            w = (a == 0) ? 16'h0008 : (a == 1) ? 16'h0007 : pat(a[3:0]);
            if (a == 2) begin
                w = {12'h000, u_prog_b.tune_interp(900, 800, 1200)};
            end
            u_prog_b.send_word(w);
            u_prog_b.ph(1'b1, 1'b0, 1'b0);
            check({write_busy_b, data_in_b}, 2'h2);
            u_prog_b.poll();
            u_prog_b.measure(per);
            check(16'(per), PERIOD_NS);
            u_prog_b.ph(1'b0, 1'b0, 1'b0);
        end
        for (int i = 0; i < 16; i++) begin
            u_prog_b.read_bit(w[i]);
        end
        check(w, 16'h0000);
        check({prog_mode_b, write_busy_b, data_oe_b, verify_spent_b}, 4'h8);
        $display("variant without read-out done");
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_entry();
        t_program();
        t_verify();
        t_variant();
        summarize();
    end
endmodule

`default_nettype wire

// *** verif/spv_programmer.sv ***
// Behavioural device programmer driving the link clock and the data pin.
`default_nettype none

module spv_programmer #(
    parameter int unsigned PH       = 10,
    parameter int unsigned SETUP_PH = 3
) (
    input  wire logic i_tick,
    input  wire logic i_data_oe,
    input  wire logic i_data_out,
    output wire logic o_link_clk,
    output wire logic o_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_q = 1'b0;
    logic drive = 1'b0;
    logic level = 1'b0;

    assign o_link_clk = clk_q;
    // A released line is held low by its pull-down.
    assign o_data_in = i_data_oe ? i_data_out : (drive & level);

    task automatic ph(input logic c, input logic d, input logic en);
        @(posedge i_tick);
        clk_q <= c;
        level <= d;
        drive <= en;
        repeat (PH - 1) @(posedge i_tick);
    endtask

    task automatic entry();
        ph(1'b1, 1'b0, 1'b1);
        ph(1'b1, 1'b1, 1'b1);
        ph(1'b0, 1'b0, 1'b1);
    endtask

    // Both lines stay low through the entry setup interval, which spans the bulk erase.
    task automatic setup();
        repeat (SETUP_PH) ph(1'b0, 1'b0, 1'b1);
    endtask

    task automatic send_word(input logic [15:0] w);
        for (int i = 0; i < 16; i++) begin
            ph(1'b1, w[i], 1'b1);
            ph(1'b0, w[i], 1'b1);
        end
    endtask

    task automatic wait_write();
        repeat (16) ph(1'b0, 1'b0, 1'b0);
    endtask

    task automatic poll();
        for (int t = 0; t < 400 && !o_data_in; t++) begin
            @(posedge i_tick);
        end
    endtask

    task automatic read_bit(output logic b);
        @(posedge i_tick);
        b = o_data_in;
        clk_q <= 1'b1;
        drive <= 1'b0;
        repeat (PH - 1) @(posedge i_tick);
        ph(1'b0, 1'b0, 1'b0);
    endtask

    // Averages four pulse periods, a power of two, for one time element.
    task automatic measure(output int unsigned per);
        realtime t0;
        @(posedge o_data_in);
        t0 = $realtime;
        repeat (4) @(posedge o_data_in);
        per = int'(($realtime - t0) / 4.0);
    endtask

    // Two-point interpolation of the tuning value from the -8 and +7 measurements.
    function automatic logic [3:0] tune_interp(input int f_ideal, input int f_low,
                                               input int f_high);
        return 4'(16 * (f_ideal - f_low) / (f_high - f_low));
    endfunction
endmodule

`default_nettype wire

// *** verif/spv_props.sv ***
// Concurrent checks on the pins of the program/verify port.
`default_nettype none

module spv_props #(
    parameter int unsigned ERASE_CYCLES  = 40,
    parameter bit          PULSE_ON_POLL = 1'b0
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_data_in,
    input wire logic o_data_out,
    input wire logic o_data_oe,
    input wire logic o_prog_mode,
    input wire logic o_write_busy,
    input wire logic o_verify_spent
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned busy_len;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !o_write_busy) begin
            busy_len <= 0;
        end else begin
            busy_len <= busy_len + 1;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    property p_spent_sticky; o_verify_spent |=> o_verify_spent; endproperty
    a_spent_sticky: assert property (p_spent_sticky) else $error("spent flag dropped");
    property p_mode_sticky; o_prog_mode |=> o_prog_mode; endproperty
    a_mode_sticky: assert property (p_mode_sticky) else $error("program mode left");
    property p_spent_when; $rose(o_verify_spent) |-> o_prog_mode && !o_write_busy; endproperty
    a_spent_when: assert property (p_spent_when) else $error("read-out end misplaced");
    property p_spent_quiet; o_verify_spent ##1 o_verify_spent |-> !o_data_oe; endproperty
    a_spent_quiet: assert property (p_spent_quiet) else $error("drive after read-out");
    property p_erase_busy; $rose(o_prog_mode) |-> ##[0:1] o_write_busy; endproperty
    a_erase_busy: assert property (p_erase_busy) else $error("no erase on entry");
    property p_erase_len; $fell(o_write_busy) |-> busy_len >= ERASE_CYCLES; endproperty
    a_erase_len: assert property (p_erase_len) else $error("busy interval too short");
    property p_poll_low;
        (o_write_busy && i_link_clk)[*5] ##1 o_write_busy |->
            $past(o_data_oe) && !$past(o_data_out);
    endproperty
    a_poll_low: assert property (p_poll_low) else $error("poll level not low");
    property p_poll_high;
        $fell(o_write_busy) && i_link_clk && !PULSE_ON_POLL |->
            ##[0:3] (o_data_oe && o_data_out);
    endproperty
    a_poll_high: assert property (p_poll_high) else $error("poll level not high");
    property p_stand;
        // Pulse-emitting variants toggle the pin while polled, so only steady ones are held.
        (!o_write_busy)[*4] ##0 (o_data_oe && i_link_clk && !PULSE_ON_POLL) |=>
            o_data_oe && $stable(o_data_out);
    endproperty
    a_stand: assert property (p_stand) else $error("data moved while clock high");
endmodule

bind serial_program_verify_port spv_props #(
    .ERASE_CYCLES(ERASE_CYCLES), .PULSE_ON_POLL(PULSE_ON_POLL)
) u_props (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_link_clk(i_link_clk),
    .i_data_in(i_data_in), .o_data_out(o_data_out), .o_data_oe(o_data_oe),
    .o_prog_mode(o_prog_mode), .o_write_busy(o_write_busy),
    .o_verify_spent(o_verify_spent)
);

`default_nettype wire
